// [hw/cfg_vc_defines.svh]
// Offsets, field positions, reset values and timing for the indirect window and channel capability bank.
`ifndef CFG_VC_DEFINES_SVH
`define CFG_VC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_INDIRECT_POINTER 12'h0f8
`define OFS_INDIRECT_DATA 12'h0fc
`define OFS_CAP_HEADER 12'h100
`define OFS_PORT_CAP_ONE 12'h104
`define OFS_RES0_CAP 12'h110
`define OFS_RES0_CTL 12'h114

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PTR_DWORD_LSB 2
`define PTR_GROUP_MSB 11
`define HDR_VERSION_LSB 16
`define HDR_LINK_LSB 20
`define PVC_EXTRA_LSB 0
`define PVC_LOW_PRIO_LSB 4
`define PVC_TIME_BASE_LSB 8
`define PVC_ENTRY_W_LSB 10
`define RES_ADV_SW_BIT 14
`define RES_SNOOP_REJ_BIT 15
`define RES_SLOT_LSB 16
`define RES_LOC_LSB 24

// ----------------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------------
`define HDR_IDENT 16'h0002
`define HDR_VERSION 4'h1
`define HDR_LINK 12'h000
`define PVC_EXTRA 3'h0
`define PVC_LOW_PRIO 3'h0
`define PVC_TIME_BASE 2'h0
`define PVC_ENTRY_W 2'h1
`define RES_ADV_SW 1'h0
`define RES_SNOOP_REJ 1'h0
`define RES_SLOT 7'h00
`define RST_ARB_MASK 8'h01
`define RST_ARB_LOC 8'h00
`define RST_CLASS_MAP 8'hff
`define RST_POINTER 10'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ANSWER_CYCLES 1

`endif

// [hw/cfg_vc_pkg.sv]
// Types shared by the indirect window and channel capability bank.
package cfg_vc_pkg;

  // --------------------------------------------------------------------------
  // Access request and answer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic wr;
    logic [9:0] dword;
    logic [3:0] be;
    logic [31:0] wdata;
    logic smbus;
    logic init;
  } cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_s;

  // --------------------------------------------------------------------------
  // Decoded target register
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_POINTER = 6'b000010,
    SEL_HEADER = 6'b000100,
    SEL_PORT_CAP = 6'b001000,
    SEL_RES_CAP = 6'b010000,
    SEL_RES_CTL = 6'b100000
  } reg_sel_e;

endpackage : cfg_vc_pkg

// [hw/cfg_indirect_and_vc_capability.sv]
// Indirect configuration window and virtual channel capability register bank.
`timescale 1ns/1ns
`include "cfg_vc_defines.svh"
// ----------------------------------------------------------------------------
// Overview of operation
// - Window read returns the register that the indirect pointer selects.
// - Window write updates the register that the indirect pointer selects.
// - Window accesses touch only the byte lanes enabled on the access.
// - Pointer aimed at the window itself: reads give zero, writes dropped.
// - Window accesses over SMBus read zero and change nothing.
// - Header bits 15:0 read 0x2, a virtual channel structure.
// - Header bits 19:16 read structure version 0x1.
// - Header bits 31:20 read zero, no further capability.
// - Port capability bits 2:0 read zero, default channel only.
// - Port capability bits 6:4 read zero, no low priority channels.
// - Port capability bits 9:8 read zero, no time based round robin.
// - Port capability bits 11:10 read 0x1, two bit table entries.
// - Arbitration ability mask resets to 0x1, fixed round robin.
// - Each mask bit is one scheme; several may be set together.
// - Resource capability bit 14 reads zero.
// - Resource capability bit 15 reads zero.
// - Resource capability bits 22:16 read zero.
// - Table location in bits 31:24, sixteen byte units, resets zero.
// - Class map resets 0xff; bit 0 fixed, bits 1 to 7 writable.
// ----------------------------------------------------------------------------
module cfg_indirect_and_vc_capability (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration access
  input wire cfg_vc_pkg::cfg_req_s req,
  output cfg_vc_pkg::cfg_rsp_s rsp
);
  import cfg_vc_pkg::*;

  // --------------------------------------------------------------------------
  // Index constants
  // --------------------------------------------------------------------------
  localparam logic [9:0] IDX_POINTER = 10'(`OFS_INDIRECT_POINTER >> 2);
  localparam logic [9:0] IDX_DATA = 10'(`OFS_INDIRECT_DATA >> 2);
  localparam logic [9:0] IDX_HEADER = 10'(`OFS_CAP_HEADER >> 2);
  localparam logic [9:0] IDX_PORT_CAP = 10'(`OFS_PORT_CAP_ONE >> 2);
  localparam logic [9:0] IDX_RES_CAP = 10'(`OFS_RES0_CAP >> 2);
  localparam logic [9:0] IDX_RES_CTL = 10'(`OFS_RES0_CTL >> 2);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [9:0] ptr_q;
  logic [7:0] arb_mask_q;
  logic [7:0] arb_loc_q;
  logic [7:1] map_q;
  cfg_rsp_s rsp_q;

  // --------------------------------------------------------------------------
  // Access steering
  // --------------------------------------------------------------------------
  wire logic is_win = req.dword == IDX_DATA;
  wire logic win_self = is_win && (ptr_q == IDX_DATA);
  wire logic win_smbus = is_win && req.smbus;
  // A blocked window access still answers, but as a zero read and a dropped write.
  wire logic win_blocked = win_self || win_smbus;
  wire logic [9:0] tgt_idx = is_win ? ptr_q : req.dword;
  wire logic wr_ok = req.valid && req.wr && !win_blocked;
  // Initialization path covers serial EEPROM load and SMBus.
  wire logic lock_ok = req.init || req.smbus;
  logic [3:0] lane_wr;
  reg_sel_e sel;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign lane_wr[lane] = wr_ok && req.be[lane];
    end
  endgenerate

  always_comb
  begin
    if (tgt_idx == IDX_POINTER)
      sel = SEL_POINTER;
    else if (tgt_idx == IDX_HEADER)
      sel = SEL_HEADER;
    else if (tgt_idx == IDX_PORT_CAP)
      sel = SEL_PORT_CAP;
    else if (tgt_idx == IDX_RES_CAP)
      sel = SEL_RES_CAP;
    else if (tgt_idx == IDX_RES_CTL)
      sel = SEL_RES_CTL;
    else
      sel = SEL_NONE;
  end

  // --------------------------------------------------------------------------
  // Read values
  // --------------------------------------------------------------------------
  wire logic [31:0] header_val = {`HDR_LINK, `HDR_VERSION, `HDR_IDENT};
  wire logic [31:0] port_cap_val = {20'h00000, `PVC_ENTRY_W, `PVC_TIME_BASE,
                                    1'b0, `PVC_LOW_PRIO, 1'b0, `PVC_EXTRA};
  // Mask bits are independent, so any combination of schemes can be reported.
  wire logic [31:0] res_cap_val = {arb_loc_q, 1'b0, `RES_SLOT, `RES_SNOOP_REJ, `RES_ADV_SW,
                                   6'h00, arb_mask_q};
  wire logic [7:0] map_val = {map_q, 1'b1};
  wire logic [31:0] res_ctl_val = {24'h000000, map_val};
  wire logic [31:0] ptr_val = {20'h00000, ptr_q, 2'b00};
  logic [31:0] rd_val;

  always_comb
  begin
    rd_val = 32'h00000000;
    if (!win_blocked)
    begin
      case (sel)
        SEL_POINTER: rd_val = ptr_val;
        SEL_HEADER: rd_val = header_val;
        SEL_PORT_CAP: rd_val = port_cap_val;
        SEL_RES_CAP: rd_val = res_cap_val;
        SEL_RES_CTL: rd_val = res_ctl_val;
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Writes
  // --------------------------------------------------------------------------
  wire logic hit_ptr = sel == SEL_POINTER;
  wire logic hit_cap = sel == SEL_RES_CAP;
  wire logic hit_ctl = sel == SEL_RES_CTL;
  // The pointer can rewrite itself through the window; the new value holds from the next access.
  wire logic [5:0] ptr_lo_d = (hit_ptr && lane_wr[0]) ? req.wdata[7:2] : ptr_q[5:0];
  wire logic [3:0] ptr_hi_d = (hit_ptr && lane_wr[1]) ? req.wdata[11:8] : ptr_q[9:6];
  wire logic mask_we = hit_cap && lane_wr[0] && lock_ok;
  wire logic loc_we = hit_cap && lane_wr[3] && lock_ok;
  wire logic map_we = hit_ctl && lane_wr[0];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q <= `RST_POINTER;
      arb_mask_q <= `RST_ARB_MASK;
      arb_loc_q <= `RST_ARB_LOC;
      map_q <= 7'(`RST_CLASS_MAP >> 1);
    end
    else
    begin
      ptr_q <= {ptr_hi_d, ptr_lo_d};
      if (mask_we)
        arb_mask_q <= req.wdata[7:0];
      if (loc_we)
        arb_loc_q <= req.wdata[31:24];
      if (map_we)
        map_q <= req.wdata[7:1];
    end
  end

  // --------------------------------------------------------------------------
  // Answer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.ack <= req.valid;
      if (req.valid && !req.wr)
        rsp_q.rdata <= rd_val;
    end
  end

  assign rsp = rsp_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  wire logic rd_req = req.valid && !req.wr;
  wire logic wr_req = req.valid && req.wr;

  property p_header_read;
    rd_req && !is_win && req.dword == IDX_HEADER |=> rsp.ack && rsp.rdata == 32'h00010002;
  endproperty
  a_header_read: assert property (p_header_read) else $error("Header read value wrong.");

  property p_port_cap_read;
    rd_req && !is_win && req.dword == IDX_PORT_CAP |=> rsp.rdata == 32'h00000400;
  endproperty
  a_port_cap_read: assert property (p_port_cap_read) else $error("Port capability value wrong.");

  property p_self_zero;
    rd_req && is_win && ptr_q == IDX_DATA |=> rsp.ack && rsp.rdata == 32'h00000000;
  endproperty
  a_self_zero: assert property (p_self_zero) else $error("Self window read not zero.");

  property p_smbus_read_zero;
    rd_req && is_win && req.smbus |=> rsp.rdata == 32'h00000000;
  endproperty
  a_smbus_read_zero: assert property (p_smbus_read_zero) else $error("SMBus window read not zero.");

  property p_smbus_write_none;
    wr_req && is_win && (req.smbus || ptr_q == IDX_DATA)
      |=> $stable(ptr_q) && $stable(arb_mask_q) && $stable(arb_loc_q) && $stable(map_q);
  endproperty
  a_smbus_write_none: assert property (p_smbus_write_none) else $error("Blocked window write changed state.");

  property p_window_read_map;
    rd_req && is_win && !req.smbus && ptr_q == IDX_RES_CTL |=> rsp.rdata == {24'h000000, $past(map_val)};
  endproperty
  a_window_read_map: assert property (p_window_read_map) else $error("Window read wrong target value.");

  property p_window_write_map;
    wr_req && is_win && !req.smbus && ptr_q == IDX_RES_CTL && req.be[0]
      |=> map_val == {$past(req.wdata[7:1]), 1'b1};
  endproperty
  a_window_write_map: assert property (p_window_write_map) else $error("Window write missed target.");

  property p_lane_gate;
    wr_req && hit_ctl && !req.be[0] |=> $stable(map_q);
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("Disabled lane was written.");

  property p_lock_hold;
    wr_req && !req.init && !req.smbus |=> $stable(arb_mask_q) && $stable(arb_loc_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("Lockable field took ordinary write.");

  property p_lock_load;
    wr_req && !is_win && req.init && req.dword == IDX_RES_CAP && req.be[0] && req.be[3]
      |=> arb_mask_q == $past(req.wdata[7:0]) && arb_loc_q == $past(req.wdata[31:24]);
  endproperty
  a_lock_load: assert property (p_lock_load) else $error("Initialization load missed.");

  property p_pointer_write;
    wr_req && !is_win && req.dword == IDX_POINTER && req.be[1:0] == 2'b11
      |=> ptr_val == {20'h00000, $past(req.wdata[11:2]), 2'b00};
  endproperty
  a_pointer_write: assert property (p_pointer_write) else $error("Pointer write lost.");

  property p_ack_timing;
    !req.valid |=> !rsp.ack;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("Answer without request.");

  c_window_read: cover property (rd_req && is_win && !win_blocked ##1 rsp.ack);
  c_window_write: cover property (wr_req && is_win && !win_blocked && hit_ctl);
  c_smbus_window: cover property (req.valid && win_smbus);
  c_lock_load: cover property (mask_we ##1 arb_mask_q != `RST_ARB_MASK);

endmodule : cfg_indirect_and_vc_capability

// [bench/cfg_requester.sv]
// Configuration requester model that drives the access port of the bank.
`timescale 1ns/1ns
module cfg_requester (
  // Clock
  input wire logic core_clk,
  // Access port
  output cfg_vc_pkg::cfg_req_s req,
  input wire cfg_vc_pkg::cfg_rsp_s rsp
);
  import cfg_vc_pkg::*;

  initial req = '0;

  // --------------------------------------------------------------------------
  // One access
  // --------------------------------------------------------------------------
  // Fields are held from one falling edge to the next, so the taking edge sees them stable.
  // The answer stands for one cycle after the taking edge, so it is read at the next falling edge before release.
  // Released data and enables are inverted, so a stale value can never pass for a fresh one.
  task automatic access(input logic wr, input logic sm, input logic in, input logic [9:0] dw,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rdata, output logic ack);
    begin
      @(negedge core_clk);
      req = '{valid: 1'b1, wr: wr, dword: dw, be: be, wdata: wd, smbus: sm, init: in};
      @(negedge core_clk);
      ack = rsp.ack;
      rdata = rsp.rdata;
      req.valid = 1'b0;
      req.wdata = ~wd;
      req.be = ~be;
    end
  endtask : access
endmodule : cfg_requester

// [bench/test_cfg_indirect_and_vc_capability.sv]
// Self-checking testbench for the indirect window and channel capability bank.
`timescale 1ns/1ns
module test_cfg_indirect_and_vc_capability;
  import cfg_vc_pkg::*;
  logic core_clk;
  logic rst;
  cfg_req_s req;
  cfg_rsp_s rsp;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic ack;

  `define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  // --------------------------------------------------------------------------
  // Instances and clock
  // --------------------------------------------------------------------------
  cfg_indirect_and_vc_capability cfg_indirect_and_vc_capability_inst (
    .core_clk(core_clk),
    .rst(rst),
    .req(req),
    .rsp(rsp)
  );

  cfg_requester cfg_requester_inst (
    .core_clk(core_clk),
    .req(req),
    .rsp(rsp)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic end_sim;
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask : end_sim

  // Every access, read or write, must be answered one cycle later.
  task automatic xfer(input logic wr, input logic sm, input logic in, input logic [9:0] dw,
    input logic [3:0] be, input logic [31:0] wd);
    begin
      cfg_requester_inst.access(wr, sm, in, dw, be, wd, rd, ack);
      `CHK(ack, 1'b1)
    end
  endtask : xfer

  task automatic wr(input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd);
    begin
      xfer(1'b1, 1'b0, 1'b0, dw, be, wd);
    end
  endtask : wr

  task automatic rchk(input logic sm, input logic [9:0] dw, input logic [31:0] exp);
    begin
      xfer(1'b0, sm, 1'b0, dw, 4'hf, 32'h0);
      `CHK(rd, exp)
    end
  endtask : rchk

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rchk(1'b0, 10'h040, 32'h00010002);
    rchk(1'b0, 10'h041, 32'h00000400);
    rchk(1'b0, 10'h044, 32'h00000001);
    rchk(1'b0, 10'h045, 32'h000000ff);
    wr(10'h044, 4'hf, 32'hffffffff);
    rchk(1'b0, 10'h044, 32'h00000001);
    xfer(1'b1, 1'b0, 1'b1, 10'h044, 4'hf, 32'hffffffff);
    rchk(1'b0, 10'h044, 32'hff0000ff);
    xfer(1'b1, 1'b1, 1'b0, 10'h044, 4'h9, 32'h02ffff03);
    rchk(1'b0, 10'h044, 32'h02000003);
    wr(10'h045, 4'h1, 32'h00000000);
    rchk(1'b0, 10'h045, 32'h00000001);
    wr(10'h03e, 4'hf, 32'hffffffff);
    rchk(1'b0, 10'h03e, 32'h00000ffc);
    // The window is used only after its pointer has been loaded.
    wr(10'h03e, 4'h3, 32'h00000114);
    wr(10'h03f, 4'h1, 32'h0000000f);
    rchk(1'b0, 10'h045, 32'h0000000f);
    wr(10'h03f, 4'h2, 32'h000000f0);
    rchk(1'b0, 10'h03f, 32'h0000000f);
    rchk(1'b1, 10'h03f, 32'h00000000);
    xfer(1'b1, 1'b1, 1'b0, 10'h03f, 4'h1, 32'h000000ff);
    rchk(1'b0, 10'h045, 32'h0000000f);
    wr(10'h03e, 4'h3, 32'h000000fc);
    rchk(1'b0, 10'h03f, 32'h00000000);
    wr(10'h03f, 4'hf, 32'h00000000);
    rchk(1'b0, 10'h03e, 32'h000000fc);
    rchk(1'b0, 10'h045, 32'h0000000f);
    wr(10'h03e, 4'h3, 32'h00000100);
    rchk(1'b0, 10'h03f, 32'h00010002);
    rchk(1'b0, 10'h050, 32'h00000000);
    // A second reset in mid-run must bring every register back to its reset value.
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rchk(1'b0, 10'h044, 32'h00000001);
    rchk(1'b0, 10'h045, 32'h000000ff);
    rchk(1'b0, 10'h03e, 32'h00000000);
    end_sim;
  end

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  // The tests need about seventy cycles; this limit leaves ample margin.
  initial
  begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    end_sim;
  end
endmodule : test_cfg_indirect_and_vc_capability
